// File: core/baps_top.sv
// Purpose: latch bus address from straps and derive switching phase offset
// Assumes: strap values are stable from reset release until latched
// Notes: peer_shared_line is open drain; the pin only ever pulls low
`timescale 1ns/1ps

module baps_top (
  input wire logic sys_clk, // System clock, 100 MHz
  input wire logic rst_b, // Asynchronous reset, active low
  input wire baps_pkg::baps_strap_s strap_in, // Digitised strap information
  input wire logic phase_wr, // Host phase override strobe
  input wire logic [3:0] phase_wr_val, // Host phase in 22.5 degree steps
  input wire logic phase_use_default, // Host request to return to default phase
  input wire logic peer_pull_req, // Block wants shared line low
  input wire logic peer_shared_line_in, // Shared line level as seen
  output logic peer_shared_line_out, // Shared line drive value, always low
  output logic peer_shared_line_oe, // Shared line pull-down enable
  output logic peer_line_low, // Registered shared line level is low
  output logic [6:0] bus_addr, // Latched bus address
  output logic addr_valid, // Address latched and usable
  output logic addr_locked, // Strap sampling finished
  output logic [3:0] phase_offset, // Active phase in 22.5 degree steps
  output logic phase_override // Host value in use
);

  // ----------------------------------------------------------------
  // Strap sampling
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_SETTLE, ST_LATCH, ST_HOLD} baps_state_e;

  baps_state_e state_r;
  baps_state_e state_nxt;
  logic [2:0] settle_r;
  baps_pkg::baps_addr_s decoded;
  wire [3:0] default_phase;
  wire settle_done;

  baps_addr_decode u_decode (
    .strap(strap_in),
    .result(decoded)
  );

  // Waiting a few cycles lets the analog front end finish its first conversion
  assign settle_done = settle_r == 3'(baps_pkg::LATCH_DELAY_CYC - 1);
  assign default_phase = {decoded.addr[2:0], 1'b0};

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_SETTLE: if (settle_done) state_nxt = ST_LATCH;
      ST_LATCH: state_nxt = ST_HOLD;
      ST_HOLD: state_nxt = ST_HOLD;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ST_SETTLE;
      settle_r <= 3'h0;
    end else begin
      state_r <= state_nxt;
      if (state_r == ST_SETTLE) settle_r <= settle_r + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // Address and phase registers
  // ----------------------------------------------------------------
  logic [3:0] default_phase_r;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      bus_addr <= baps_pkg::ADDR_RESET;
      addr_valid <= 1'b0;
      addr_locked <= 1'b0;
      default_phase_r <= baps_pkg::PHASE_RESET;
    end else if (state_r == ST_LATCH) begin
      bus_addr <= decoded.addr;
      addr_valid <= decoded.valid;
      addr_locked <= 1'b1;
      default_phase_r <= default_phase;
    end
  end

  // Host writes before the straps are latched are ignored so default wins at start-up
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_offset <= baps_pkg::PHASE_RESET;
      phase_override <= 1'b0;
    end else if (state_r == ST_LATCH) begin
      phase_offset <= default_phase;
    end else if (state_r == ST_HOLD) begin
      if (phase_wr) begin
        phase_offset <= phase_wr_val;
        phase_override <= 1'b1;
      end else if (phase_use_default) begin
        phase_offset <= default_phase_r;
        phase_override <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Shared peer line
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      peer_shared_line_out <= 1'b0;
      peer_shared_line_oe <= 1'b0;
      peer_line_low <= 1'b0;
    end else begin
      peer_shared_line_out <= 1'b0;
      peer_shared_line_oe <= peer_pull_req;
      peer_line_low <= !peer_shared_line_in;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_level_addr;
    @(posedge sys_clk) disable iff (!rst_b)
      (state_r == ST_LATCH && strap_in.mode == baps_pkg::BAPS_MODE_LEVEL)
      |=> bus_addr == 7'h20 + 7'(3 * $past(strap_in.high_level)) + 7'($past(strap_in.low_level));
  endproperty
  a_level_addr: assert property (p_level_addr) else $error("level address wrong");

  property p_reserved;
    @(posedge sys_clk) disable iff (!rst_b)
      (state_r == ST_LATCH && strap_in.mode == baps_pkg::BAPS_MODE_LEVEL &&
       strap_in.high_level == 2'h2 && strap_in.low_level == 2'h2) |=> !addr_valid;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved strap decoded valid");

  property p_single;
    @(posedge sys_clk) disable iff (!rst_b)
      (state_r == ST_LATCH && strap_in.mode == baps_pkg::BAPS_MODE_SINGLE)
      |=> bus_addr == {2'h0, $past(strap_in.low_index)};
  endproperty
  a_single: assert property (p_single) else $error("single index address wrong");

  property p_dual;
    @(posedge sys_clk) disable iff (!rst_b)
      (state_r == ST_LATCH && strap_in.mode == baps_pkg::BAPS_MODE_DUAL)
      |=> bus_addr == 7'((25 * $past(strap_in.high_index) + $past(strap_in.low_index)) % 128);
  endproperty
  a_dual: assert property (p_dual) else $error("dual index address wrong");

  property p_default_phase;
    @(posedge sys_clk) disable iff (!rst_b)
      (addr_locked && !phase_override) |-> phase_offset == {bus_addr[2:0], 1'b0};
  endproperty
  a_default_phase: assert property (p_default_phase) else $error("default phase wrong");

  property p_override;
    @(posedge sys_clk) disable iff (!rst_b)
      (state_r == ST_HOLD && phase_wr) |=> phase_offset == $past(phase_wr_val) && phase_override;
  endproperty
  a_override: assert property (p_override) else $error("phase override not taken");

  property p_open_drain;
    @(posedge sys_clk) disable iff (!rst_b)
      peer_pull_req |=> peer_shared_line_oe && !peer_shared_line_out;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("shared line driven high");

  property p_hold;
    @(posedge sys_clk) disable iff (!rst_b)
      addr_locked |=> addr_locked && $stable(bus_addr) && $stable(addr_valid);
  endproperty
  a_hold: assert property (p_hold) else $error("latched address changed");

  property p_lock_timing;
    @(posedge sys_clk) disable iff (!rst_b)
      (state_r == ST_LATCH) |=> addr_locked;
  endproperty
  a_lock_timing: assert property (p_lock_timing) else $error("lock late");

  property p_early_write;
    @(posedge sys_clk) disable iff (!rst_b)
      (state_r == ST_SETTLE) |=> !phase_override && phase_offset == baps_pkg::PHASE_RESET;
  endproperty
  a_early_write: assert property (p_early_write) else $error("early phase write taken");

  property p_phase_stable;
    @(posedge sys_clk) disable iff (!rst_b)
      addr_locked |=> $stable(default_phase_r);
  endproperty
  a_phase_stable: assert property (p_phase_stable) else $error("default phase moved");

  property p_restore;
    @(posedge sys_clk) disable iff (!rst_b)
      (state_r == ST_HOLD && !phase_wr && phase_use_default)
      |=> !phase_override && phase_offset == {bus_addr[2:0], 1'b0};
  endproperty
  a_restore: assert property (p_restore) else $error("default phase not restored");

  property p_dual_range;
    @(posedge sys_clk) disable iff (!rst_b)
      (state_r == ST_LATCH && strap_in.mode == baps_pkg::BAPS_MODE_DUAL &&
       (strap_in.high_index > 5'h18 || strap_in.low_index > 5'h18)) |=> !addr_valid;
  endproperty
  a_dual_range: assert property (p_dual_range) else $error("bad index valid");

  property p_mode_rsvd;
    @(posedge sys_clk) disable iff (!rst_b)
      (state_r == ST_LATCH && strap_in.mode == baps_pkg::BAPS_MODE_RSVD) |=> !addr_valid;
  endproperty
  a_mode_rsvd: assert property (p_mode_rsvd) else $error("bad mode valid");

  property p_release;
    @(posedge sys_clk) disable iff (!rst_b)
      !peer_pull_req |=> !peer_shared_line_oe;
  endproperty
  a_release: assert property (p_release) else $error("shared line not released");

  property p_sense_high;
    @(posedge sys_clk) disable iff (!rst_b)
      peer_shared_line_in |=> !peer_line_low;
  endproperty
  a_sense_high: assert property (p_sense_high) else $error("line high seen low");

  property p_sense_low;
    @(posedge sys_clk) disable iff (!rst_b)
      !peer_shared_line_in |=> peer_line_low;
  endproperty
  a_sense_low: assert property (p_sense_low) else $error("line low not seen");

endmodule : baps_top

// File: core/baps_pkg.sv
// Purpose: shared constants and carriers for the bus address and phase offset selector
// Assumes: strap levels and resistor indexes arrive already digitised, synchronous to sys_clk
// Notes: phase offsets are counted in 22.5 degree steps, 16 steps per full cycle
package baps_pkg;

  // ----------------------------------------------------------------
  // Strap encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BAPS_LVL_LOW  = 2'h0,
    BAPS_LVL_OPEN = 2'h1,
    BAPS_LVL_HIGH = 2'h2,
    BAPS_LVL_BAD  = 2'h3
  } baps_level_e;

  typedef enum logic [1:0] {
    BAPS_MODE_LEVEL  = 2'h0,
    BAPS_MODE_SINGLE = 2'h1,
    BAPS_MODE_DUAL   = 2'h2,
    BAPS_MODE_RSVD   = 2'h3
  } baps_mode_e;

  // ----------------------------------------------------------------
  // Address and phase constants
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_LEVEL_BASE = 7'h20;
  localparam logic [4:0] INDEX_MAX = 5'h18;
  localparam logic [4:0] INDEX_MULT = 5'h19;
  localparam logic [1:0] LEVEL_MULT = 2'h3;
  localparam logic [6:0] ADDR_RESET = 7'h00;
  localparam logic [3:0] PHASE_RESET = 4'h0;
  localparam int PHASE_STEPS_PER_ADDR = 2;
  localparam int LATCH_DELAY_CYC = 4;

  typedef struct packed {
    baps_mode_e mode;
    logic [1:0] low_level;
    logic [1:0] high_level;
    logic [4:0] low_index;
    logic [4:0] high_index;
  } baps_strap_s;

  typedef struct packed {
    logic [6:0] addr;
    logic valid;
  } baps_addr_s;

endpackage : baps_pkg

// File: core/baps_addr_decode.sv
// Purpose: combinational strap to bus address decode
// Assumes: strap inputs are stable while sampled
// Notes: valid is low for the reserved combination and out of range values
`timescale 1ns/1ps
module baps_addr_decode (
  input wire baps_pkg::baps_strap_s strap, // Strap levels and indexes
  output baps_pkg::baps_addr_s result // Decoded address and validity
);

  wire [8:0] level_sum;
  wire [9:0] dual_sum;
  wire level_rsvd;
  wire level_bad;
  wire index_bad;
  wire single_bad;

  assign level_sum = {7'h00, strap.high_level} * {7'h00, baps_pkg::LEVEL_MULT}
                     + {7'h00, strap.low_level};
  assign dual_sum = {5'h00, strap.high_index} * {5'h00, baps_pkg::INDEX_MULT}
                    + {5'h00, strap.low_index};
  assign level_rsvd = (strap.high_level == baps_pkg::BAPS_LVL_HIGH) &&
                      (strap.low_level == baps_pkg::BAPS_LVL_HIGH);
  assign level_bad = (strap.high_level == baps_pkg::BAPS_LVL_BAD) ||
                     (strap.low_level == baps_pkg::BAPS_LVL_BAD);
  assign index_bad = (strap.low_index > baps_pkg::INDEX_MAX) ||
                     (strap.high_index > baps_pkg::INDEX_MAX);
  assign single_bad = strap.low_index > baps_pkg::INDEX_MAX;

  always_comb begin
    result = '{addr: baps_pkg::ADDR_RESET, valid: 1'b0};
    unique case (strap.mode)
      baps_pkg::BAPS_MODE_LEVEL: begin
        result.addr = baps_pkg::ADDR_LEVEL_BASE + level_sum[6:0];
        result.valid = !level_rsvd && !level_bad;
      end
      baps_pkg::BAPS_MODE_SINGLE: begin
        result.addr = {2'h0, strap.low_index};
        result.valid = !single_bad;
      end
      baps_pkg::BAPS_MODE_DUAL: begin
        result.addr = dual_sum[6:0];
        result.valid = !index_bad;
      end
      default: begin
        result.addr = baps_pkg::ADDR_RESET;
        result.valid = 1'b0;
      end
    endcase
  end

endmodule : baps_addr_decode

// File: testbench/baps_peer_model.sv
// Purpose: peers on the shared open-drain line, with the board pull-up
// Assumes: the block drives the pin only through its output enable
// Notes: nobody drives high; the released line floats to the pull-up level
`timescale 1ns/1ps
module baps_peer_model (
  input wire logic dut_oe, // Block pull-down enable
  input wire logic dut_out, // Block drive value
  input wire logic peer_pull, // Another member pulls low
  output logic line_lvl // Resolved wire level
);
  // ----------------------------------------------------------------
  // Wired-AND with pull-up
  // ----------------------------------------------------------------
  assign line_lvl = !((dut_oe && !dut_out) || peer_pull);
endmodule : baps_peer_model

// File: testbench/baps_top_bench.sv
// Purpose: self-checking bench for the strap address and phase selector
// Assumes: straps are presented before reset release and held until lock
// Notes: every strap case needs its own reset, since straps latch only once
`timescale 1ns/1ps
module baps_top_bench;
  logic sys_clk, rst_b, phase_wr, phase_use_default, peer_pull_req, peer_pull, line_lvl;
  logic [3:0] phase_wr_val, phase_offset;
  logic [6:0] bus_addr;
  logic out_v, oe_v, line_low, addr_valid, addr_locked, phase_override;
  baps_pkg::baps_strap_s strap_in;
  int failures, num_checks, cyc;

  baps_peer_model peer_u (.dut_oe(oe_v), .dut_out(out_v), .peer_pull(peer_pull),
    .line_lvl(line_lvl));
  baps_top dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .strap_in(strap_in), .phase_wr(phase_wr),
    .phase_wr_val(phase_wr_val), .phase_use_default(phase_use_default),
    .peer_pull_req(peer_pull_req), .peer_shared_line_in(line_lvl),
    .peer_shared_line_out(out_v), .peer_shared_line_oe(oe_v), .peer_line_low(line_low),
    .bus_addr(bus_addr), .addr_valid(addr_valid), .addr_locked(addr_locked),
    .phase_offset(phase_offset), .phase_override(phase_override));

  // ----------------------------------------------------------------
  // Clock, timeout and shared tasks
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc > 3000) begin
      failures++;
      stop_test();
    end
  end

  task check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task stop_test;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test

  // Reset for 5 cycles, then count edges until the latch reports done
  task boot(input logic [1:0] m, hl, ll, input logic [4:0] hi, li);
    int n;
    @(negedge sys_clk);
    rst_b = 1'b0;
    strap_in = '{mode: baps_pkg::baps_mode_e'(m), low_level: ll, high_level: hl,
                 low_index: li, high_index: hi};
    repeat (5) @(negedge sys_clk);
    rst_b = 1'b1;
    n = 0;
    while (addr_locked !== 1'b1 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    check(8'(n), 8'(baps_pkg::LATCH_DELAY_CYC + 1));
  endtask : boot

  task strap_case(input logic [1:0] m, hl, ll, input logic [4:0] hi, li,
                  input logic [7:0] ea, input logic ev);
    boot(m, hl, ll, hi, li);
    check({7'h00, addr_valid}, {7'h00, ev});
    if (ev) begin
      check({1'b0, bus_addr}, ea);
      check({4'h0, phase_offset}, {4'h0, ea[2:0], 1'b0});
    end
  endtask : strap_case

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task level_straps;
    for (int h = 0; h < 3; h++) begin
      for (int l = 0; l < 3; l++) begin
        strap_case(2'h0, 2'(h), 2'(l), 5'h00, 5'h00, 8'(8'h20 + 3 * h + l),
                   !(h == 2 && l == 2));
      end
    end
  endtask : level_straps

  task resistor_straps;
    strap_case(2'h1, 2'h0, 2'h0, 5'h00, 5'h00, 8'h00, 1'b1);
    strap_case(2'h1, 2'h0, 2'h0, 5'h00, 5'h18, 8'h18, 1'b1);
    strap_case(2'h2, 2'h0, 2'h0, 5'h04, 5'h18, 8'h7C, 1'b1);
    strap_case(2'h2, 2'h0, 2'h0, 5'h01, 5'h03, 8'h1C, 1'b1);
    strap_case(2'h2, 2'h0, 2'h0, 5'h05, 5'h04, 8'h01, 1'b1);
    strap_case(2'h2, 2'h0, 2'h0, 5'h05, 5'h03, 8'h00, 1'b1);
    strap_case(2'h2, 2'h0, 2'h0, 5'h19, 5'h00, 8'h00, 1'b0);
    strap_case(2'h2, 2'h0, 2'h0, 5'h00, 5'h19, 8'h00, 1'b0);
    strap_case(2'h1, 2'h0, 2'h0, 5'h00, 5'h19, 8'h00, 1'b0);
    strap_case(2'h3, 2'h0, 2'h0, 5'h00, 5'h00, 8'h00, 1'b0);
    strap_case(2'h0, 2'h3, 2'h0, 5'h00, 5'h00, 8'h00, 1'b0);
  endtask : resistor_straps

  task phase_write(input logic [3:0] v, input logic dflt);
    phase_wr = !dflt;
    phase_use_default = dflt;
    phase_wr_val = v;
    @(negedge sys_clk);
    phase_wr = 1'b0;
    phase_use_default = 1'b0;
    check({4'h0, phase_offset}, {4'h0, v});
    check({7'h00, phase_override}, {7'h00, !dflt});
    @(negedge sys_clk);
  endtask : phase_write

  task phase_and_hold;
    @(negedge sys_clk);
    rst_b = 1'b0;
    strap_in = '{mode: baps_pkg::BAPS_MODE_LEVEL, low_level: 2'h2, high_level: 2'h0,
                 low_index: 5'h00, high_index: 5'h00};
    repeat (5) @(negedge sys_clk);
    rst_b = 1'b1;
    phase_wr = 1'b1;
    phase_wr_val = 4'hF;
    @(negedge sys_clk);
    phase_wr = 1'b0;
    repeat (8) @(negedge sys_clk);
    check({4'h0, phase_offset}, 8'h04);
    check({7'h00, phase_override}, 8'h00);
    phase_write(4'hF, 1'b0);
    phase_write(4'h1, 1'b0);
    phase_write(4'h4, 1'b1);
    strap_in.low_level = 2'h0;
    repeat (3) @(negedge sys_clk);
    check({1'b0, bus_addr}, 8'h22);
  endtask : phase_and_hold

  task shared_line;
    peer_pull_req = 1'b1;
    @(negedge sys_clk);
    check({6'h00, oe_v, out_v}, 8'h02);
    check({7'h00, line_lvl}, 8'h00);
    @(negedge sys_clk);
    check({7'h00, line_low}, 8'h01);
    peer_pull_req = 1'b0;
    peer_pull = 1'b1;
    repeat (2) @(negedge sys_clk);
    check({6'h00, oe_v, line_low}, 8'h01);
    peer_pull = 1'b0;
    repeat (2) @(negedge sys_clk);
    check({6'h00, line_lvl, line_low}, 8'h02);
  endtask : shared_line

  initial begin
    rst_b = 1'b0;
    phase_wr = 1'b0;
    phase_use_default = 1'b0;
    phase_wr_val = 4'h0;
    peer_pull_req = 1'b0;
    peer_pull = 1'b0;
    strap_in = '0;
    level_straps();
    resistor_straps();
    phase_and_hold();
    shared_line();
    stop_test();
  end
endmodule : baps_top_bench
